// ---- hdl/csa_ack_iack.sv ----
// Notes on behaviour
// (R01) Timing field picks internal or external acknowledge
// (R02) Codes 0..13: that many waits, 3+n cycles
// (R03) Code 14: fast termination in two cycles
// (R04) Code 15: external device drives acknowledge
// (R05) Space field qualifies select by access space
// (R06) CPU space: match level on address 3:1
// (R07) Level 0 matches any; 1..7 exact
// (R08) Autovector set: device drives autovector, ends cycle
// (R09) Autovector clear: external device supplies vector
// (R10) Mode 0: async, strobe-timed, timing field applies
// (R11) Read/write field restricts select
// (R12) Waits counted per clock from cycle start
module csa_ack_iack (
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  input  wire csa_pkg::csa_opt_t   opt,
  input  wire csa_pkg::csa_cycle_t cyc,
  input  wire logic                address_strobe_n,
  input  wire logic                data_strobe_n,
  input  wire logic                ext_ack_n,
  output logic                     chip_select_n,
  output logic                     strobe_acknowledge_n,
  output logic                     autovector_n,
  output logic                     cycle_done
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_ff <= 3'h7;
      sync2_ff <= 3'h7;
    end else begin
      sync1_ff <= {ext_ack_n, data_strobe_n, address_strobe_n};
      sync2_ff <= sync1_ff;
    end
  end

  wire as_act  = ~sync2_ff[0];
  wire ds_act  = ~sync2_ff[1];
  wire ext_ack = ~sync2_ff[2];

  // ---------------------------------------------------------------------------
  // Qualification
  // ---------------------------------------------------------------------------
  wire async_mode = ~opt.sync_mode; // (R10)

  wire rw_ok = (opt.rw_sel == csa_pkg::CSA_RW_ALL) ||
               (opt.rw_sel == csa_pkg::CSA_RW_READ  &&  cyc.rd_nwr) ||
               (opt.rw_sel == csa_pkg::CSA_RW_WRITE && !cyc.rd_nwr); // (R11)

  wire lvl_ok = (opt.iack_level_match == csa_pkg::LVL_ANY) ||
                (opt.iack_level_match == cyc.addr_lvl); // (R07)

  wire iack_hit = (opt.space_sel == csa_pkg::CSA_SP_CPU) && cyc.cpu_space &&
                  cyc.iack_cycle && lvl_ok; // (R06)

  wire mem_hit = !cyc.cpu_space && cyc.base_match &&
                 ((opt.space_sel == csa_pkg::CSA_SP_BOTH) ||
                  (opt.space_sel == csa_pkg::CSA_SP_SUPV &&  cyc.supv) ||
                  (opt.space_sel == csa_pkg::CSA_SP_USER && !cyc.supv)); // (R05)

  wire sel_ok   = async_mode && rw_ok && (iack_hit || mem_hit);
  wire strobe   = opt.strb_sel ? ds_act : as_act; // (R10)
  wire autovector_enable_use = iack_hit && opt.autovector_enable; // (R08)

  // Autovector and fast/wait codes terminate internally
  wire ext_mode = (opt.ack_timing_field == csa_pkg::ACK_EXTERNAL) && !autovector_enable_use; // (R01) (R04)
  wire fast     = (opt.ack_timing_field == csa_pkg::ACK_FAST); // (R03)

  // Cycle 0 is the first strobe clock; ack lands on total-1
  wire [3:0] target = fast ? 4'(csa_pkg::FAST_CYCLES - 4'h2) :
                             4'(opt.ack_timing_field + csa_pkg::BASE_CYCLES - 4'h2); // (R02)

  // ---------------------------------------------------------------------------
  // Cycle sequencer
  // ---------------------------------------------------------------------------
  csa_pkg::csa_state_t st_ff;
  csa_pkg::csa_state_t nxt_st;
  logic                cs_ff;
  logic                ack_ff;
  logic                autovector_enable_ff;
  logic                hit;

  wire cnt_clr = (st_ff != csa_pkg::CSA_WAIT);

  csa_wait_cnt #(.W(4)) u_cnt (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clr      (cnt_clr),
    .target   (target),
    .hit      (hit)
  );

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      csa_pkg::CSA_IDLE: begin
        if (as_act && sel_ok) nxt_st = csa_pkg::CSA_WAIT;
      end
      csa_pkg::CSA_WAIT: begin
        if (!as_act) nxt_st = csa_pkg::CSA_IDLE;
        else if (ext_mode) begin
          if (ext_ack) nxt_st = csa_pkg::CSA_ACK; // (R04) (R09)
        end else if (hit) nxt_st = csa_pkg::CSA_ACK; // (R12)
      end
      csa_pkg::CSA_ACK: begin
        nxt_st = as_act ? csa_pkg::CSA_HOLD : csa_pkg::CSA_IDLE;
      end
      csa_pkg::CSA_HOLD: begin
        if (!as_act) nxt_st = csa_pkg::CSA_IDLE;
      end
      default: nxt_st = csa_pkg::CSA_IDLE;
    endcase
  end

  // Ack and autovector held until the bus master drops its strobe;
  // an externally ended cycle passes the ack state without driving ack
  wire nxt_cs   = (nxt_st != csa_pkg::CSA_IDLE) && strobe;
  wire nxt_ack  = (nxt_st == csa_pkg::CSA_ACK || (nxt_st == csa_pkg::CSA_HOLD && ack_ff)) &&
                  !autovector_enable_use && !ext_mode; // (R02) (R03) (R04)
  wire nxt_autovector_enable = (nxt_st == csa_pkg::CSA_ACK || (nxt_st == csa_pkg::CSA_HOLD && autovector_enable_ff)) &&
                  autovector_enable_use; // (R08)

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff   <= csa_pkg::CSA_IDLE;
      cs_ff   <= 1'b0;
      ack_ff  <= 1'b0;
      autovector_enable_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      cs_ff   <= nxt_cs;
      ack_ff  <= nxt_ack;
      autovector_enable_ff <= nxt_autovector_enable;
    end
  end

  assign chip_select_n        = ~cs_ff;
  assign strobe_acknowledge_n = ~ack_ff;
  assign autovector_n         = ~autovector_enable_ff;
  assign cycle_done           = (st_ff == csa_pkg::CSA_ACK);

endmodule : csa_ack_iack

// ---- hdl/csa_pkg.sv ----
package csa_pkg;

  // ---------------------------------------------------------------------------
  // Option word layout
  // ---------------------------------------------------------------------------
  localparam int unsigned OPT_AUTOVECTOR_ENABLE_POS   = 0;
  localparam int unsigned OPT_LVL_POS    = 1;
  localparam int unsigned OPT_SPACE_POS  = 4;
  localparam int unsigned OPT_ACK_POS    = 6;
  localparam int unsigned OPT_STRB_POS   = 10;
  localparam int unsigned OPT_RW_POS     = 11;
  localparam int unsigned OPT_MODE_POS   = 15;
  localparam logic [15:0] OPT_RESET      = 16'h0000;

  // ---------------------------------------------------------------------------
  // Field codes
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ACK_WAIT_MAX    = 4'hd;
  localparam logic [3:0] ACK_FAST        = 4'he;
  localparam logic [3:0] ACK_EXTERNAL    = 4'hf;
  localparam logic [3:0] BASE_CYCLES     = 4'h3;
  localparam logic [3:0] FAST_CYCLES     = 4'h2;
  localparam logic [2:0] LVL_ANY         = 3'h0;

  typedef enum logic [1:0] {
    CSA_SP_CPU  = 2'b00,
    CSA_SP_USER = 2'b01,
    CSA_SP_SUPV = 2'b10,
    CSA_SP_BOTH = 2'b11
  } csa_space_t;

  typedef enum logic [1:0] {
    CSA_RW_OFF   = 2'b00,
    CSA_RW_READ  = 2'b01,
    CSA_RW_WRITE = 2'b10,
    CSA_RW_ALL   = 2'b11
  } csa_rw_t;

  typedef enum logic [1:0] {
    CSA_IDLE = 2'b00,
    CSA_WAIT = 2'b01,
    CSA_ACK  = 2'b10,
    CSA_HOLD = 2'b11
  } csa_state_t;

  typedef struct packed {
    logic       sync_mode;
    logic [1:0] byte_opt;
    csa_rw_t    rw_sel;
    logic       strb_sel;
    logic [3:0] ack_timing_field;
    csa_space_t space_sel;
    logic [2:0] iack_level_match;
    logic       autovector_enable;
  } csa_opt_t;

  typedef struct packed {
    logic       base_match;
    logic       rd_nwr;
    logic       supv;
    logic       cpu_space;
    logic       iack_cycle;
    logic [3:1] addr_lvl;
  } csa_cycle_t;

endpackage : csa_pkg

// ---- hdl/csa_wait_cnt.sv ----
module csa_wait_cnt #(
  parameter int unsigned W = 4
) (
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic         clr,
  input  wire logic [W-1:0] target,
  output logic              hit
);

  initial begin
    if (W < 4) $error("csa_wait_cnt: width too small");
  end

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // ---------------------------------------------------------------------------
  // Count from cycle start; saturates so a stuck cycle cannot wrap
  // ---------------------------------------------------------------------------
  assign nxt_cnt = clr ? '0 : ((cnt_ff == '1) ? cnt_ff : W'(cnt_ff + 1'b1)); // (R12)
  assign hit     = (cnt_ff == target); // (R12)

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : csa_wait_cnt

// ---- dv/csa_ack_iack_properties.sv ----
module csa_ack_iack_props (
  input wire logic                core_clk,
  input wire logic                arst_n,
  input wire csa_pkg::csa_opt_t   opt,
  input wire csa_pkg::csa_cycle_t cyc,
  input wire logic                address_strobe_n,
  input wire logic                data_strobe_n,
  input wire logic                ext_ack_n,
  input wire logic                chip_select_n,
  input wire logic                strobe_acknowledge_n,
  input wire logic                autovector_n,
  input wire logic                cycle_done
);
  // ----
  // Strobe age, saturating
  // ----
  logic [4:0] as_cnt_ff;
  logic [3:0] code;
  assign code = opt.ack_timing_field;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) as_cnt_ff <= 5'h00;
    else if (address_strobe_n) as_cnt_ff <= 5'h00;
    else if (as_cnt_ff != 5'h1f) as_cnt_ff <= as_cnt_ff + 5'h01;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_wait_ack_time: assert property ($fell(strobe_acknowledge_n) && code <= csa_pkg::ACK_WAIT_MAX
    |-> as_cnt_ff == {1'b0, code} + 5'h05) else $error("wait ack off count");
  a_fast_ack_time: assert property ($fell(strobe_acknowledge_n) && code == csa_pkg::ACK_FAST
    |-> as_cnt_ff == 5'h04) else $error("fast ack off count");
  a_ext_no_ack: assert property ((code == csa_pkg::ACK_EXTERNAL)[*4] |-> strobe_acknowledge_n)
    else $error("internal ack in external mode");
  a_ext_ack_done: assert property (code == csa_pkg::ACK_EXTERNAL && !chip_select_n
    && $fell(ext_ack_n) |-> ##[1:6] cycle_done) else $error("external ack not taken");
  a_sync_quiet: assert property ((opt.sync_mode)[*5] |-> chip_select_n)
    else $error("select in sync mode");
  a_rw_off_quiet: assert property ((opt.rw_sel == csa_pkg::CSA_RW_OFF)[*5] |-> chip_select_n)
    else $error("select with rw off");
  a_level_mismatch: assert property ((cyc.iack_cycle && opt.iack_level_match != csa_pkg::LVL_ANY
    && opt.iack_level_match != cyc.addr_lvl)[*5] |-> chip_select_n && autovector_n)
    else $error("iack on wrong level");
  a_autovector_enable_cause: assert property ($fell(autovector_n) |-> opt.autovector_enable
    && cyc.iack_cycle && opt.space_sel == csa_pkg::CSA_SP_CPU) else $error("stray autovector");
  a_release_ends: assert property ($rose(address_strobe_n) |-> ##4 chip_select_n
    && strobe_acknowledge_n && autovector_n) else $error("outputs stuck after release");
  cover property ($fell(strobe_acknowledge_n));
  cover property ($fell(autovector_n));
  cover property (cycle_done && code == csa_pkg::ACK_EXTERNAL);
endmodule : csa_ack_iack_props

bind csa_ack_iack csa_ack_iack_props u_props (.core_clk(core_clk), .arst_n(arst_n), .opt(opt),
  .cyc(cyc), .address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n),
  .ext_ack_n(ext_ack_n), .chip_select_n(chip_select_n),
  .strobe_acknowledge_n(strobe_acknowledge_n), .autovector_n(autovector_n),
  .cycle_done(cycle_done));

// ---- dv/csa_ext_dev.sv ----
module csa_ext_dev (
  input wire logic       core_clk,
  input wire logic       chip_select_n,
  input wire logic       address_strobe_n,
  input wire logic       en,
  input wire logic [3:0] dly,
  output logic           ext_ack_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Slave answers dly+1 clocks after select
  // ----
  logic [3:0] cnt_ff;
  initial ext_ack_n = 1'b1;
  always @(posedge core_clk) begin
    if (address_strobe_n || !en) begin
      cnt_ff <= 4'h0;
      ext_ack_n <= 1'b1;
    end else if (!chip_select_n) begin
      cnt_ff <= cnt_ff + 4'h1;
      if (cnt_ff == dly) ext_ack_n <= 1'b0;
    end
  end
endmodule : csa_ext_dev

// ---- dv/csa_ack_iack_tb_top.sv ----
module csa_ack_iack_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, arst_n = 1'b0, asn = 1'b1, dsn = 1'b1, ext_en = 1'b0;
  csa_pkg::csa_opt_t opt = csa_pkg::OPT_RESET;
  csa_pkg::csa_cycle_t cyc = 8'h00;
  logic [3:0] dly = 4'h1;
  logic ext_ack_n, cs_n, ack_n, autovector_enable_n, done, cs, av, dn;
  logic [7:0] n;
  int bad_count = 0, checks_done = 0;
  always #25 core_clk = ~core_clk;
  csa_ack_iack dut (.core_clk(core_clk), .arst_n(arst_n), .opt(opt), .cyc(cyc),
    .address_strobe_n(asn), .data_strobe_n(dsn), .ext_ack_n(ext_ack_n),
    .chip_select_n(cs_n), .strobe_acknowledge_n(ack_n), .autovector_n(autovector_enable_n),
    .cycle_done(done));
  csa_ext_dev dev (.core_clk(core_clk), .chip_select_n(cs_n), .address_strobe_n(asn),
    .en(ext_en), .dly(dly), .ext_ack_n(ext_ack_n));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  // Counts clocks until ack; holds strobes long enough for any wait code
  task automatic run(input logic [15:0] o, input logic [7:0] c);
    n = 8'h00; cs = 1'b0; av = 1'b0; dn = 1'b0;
    opt = o; cyc = c;
    repeat (3) @(negedge core_clk);
    asn = 1'b0; dsn = 1'b0;
    for (int i = 1; i < 30; i++) begin
      @(negedge core_clk);
      if (cs_n === 1'b0) cs = 1'b1;
      if (autovector_enable_n === 1'b0) av = 1'b1;
      if (done === 1'b1) dn = 1'b1;
      if (ack_n === 1'b0 && n == 8'h00) n = 8'(i);
    end
    asn = 1'b1; dsn = 1'b1;
    repeat (6) @(negedge core_clk);
  endtask : run
  task automatic t_waits;
    for (int k = 0; k < 15; k++) begin
      run(16'h1820 | (16'(k) << 6) | (16'(k & 1) << 10), 8'he0);
      chk(n, (k == 14) ? 8'h04 : 8'(k + 5));
      chk(8'(cs), 8'h01);
      chk(8'(dn), 8'h01);
    end
  endtask : t_waits
  task automatic t_ext;
    ext_en = 1'b1;
    for (int d = 1; d < 8; d += 5) begin
      dly = 4'(d);
      run(16'h1be0, 8'he0);
      chk(n, 8'h00);
      chk(8'(cs), 8'h01);
      chk(8'(dn), 8'h01);
    end
    ext_en = 1'b0;
  endtask : t_ext
  task automatic t_qualify;
    logic [15:0] o[5] = '{16'h0020, 16'h0820, 16'h9820, 16'h1810, 16'h1020};
    logic [7:0] c[5] = '{8'he0, 8'ha0, 8'he0, 8'he0, 8'ha0};
    for (int k = 0; k < 5; k++) begin
      run(o[k], c[k]);
      chk(8'(cs), (k == 4) ? 8'h01 : 8'h00);
    end
  endtask : t_qualify
  task automatic t_iack;
    logic [3:0] lv[5] = '{4'h1, 4'h7, 4'h7, 4'he, 4'h3};
    logic [2:0] al[5] = '{3'h5, 3'h3, 3'h4, 3'h7, 3'h1};
    for (int k = 0; k < 5; k++) begin
      ext_en = (k == 3);
      run(16'h1bc0 | 16'(lv[k]), 8'hf8 | 8'(al[k]));
      chk(8'(cs), (k == 2) ? 8'h00 : 8'h01);
      chk(8'(av), (k == 2 || k == 3) ? 8'h00 : 8'h01);
    end
    ext_en = 1'b0;
  endtask : t_iack
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  initial begin
    #200000;
    bad_count++;
    final_report();
  end
  initial begin
    repeat (2) @(negedge core_clk);
    arst_n = 1'b1;
    t_waits();
    t_ext();
    t_qualify();
    t_iack();
    final_report();
  end
endmodule : csa_ack_iack_tb_top
